// ---- hdl/twe_slave.sv ----
// EEPROM device end of the two-wire link: framing, ack, write cycle.
// Assumes resetn_in is the power-on reset; a floating protect pin
// must be pulled low by the pad ring.
//
// Contract
// - 128 bytes of eight-bit storage
// - address and direction share one byte
// - master frames operations with START, STOP
// - device acks each written byte
// - master acks each byte it reads; the master here leaves the last read byte unacked
// - reset disables everything, ignores bus
// - protect input high enables write protection
// - floating protect input reads as low
// - master clocks; device only slave
// - START is SDA fall, SCL high
// - ignore bus until START seen
// - STOP is SDA rise, SCL high
// - STOP after read returns to standby
// - STOP after write starts programming
// - transmitter releases, receiver acks ninth bit
// - sample SDA on SCL rise
// - master changes SDA only with SCL low
// - SDA driven open-drain only
// - seven address bits MSB first, then direction
// - protect during address blocks data acks
// - page writes wrap two low bits
// - bus ignored during programming cycle
`default_nettype none
`include "twe_regs.svh"

// ==========================================
// Line synchroniser and glitch filter
module twe_deglitch (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic line_in,
    output logic level_out
);
    // Two-stage synchroniser; first stage read only by the second
    logic sync_a;
    logic sync_b;
    // Cycles the synced level has differed from the output
    logic [7:0] run;

    // Synchroniser, idle-high after reset
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else begin
            sync_a <= line_in;
            sync_b <= sync_a;
        end
    end

    // filter short pulses
    // Output follows only after a steady run; costs latency, far below bus setup times
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            run <= 8'h00;
            level_out <= 1'b1;
        end else if (sync_b == level_out) begin
            run <= 8'h00;
        end else if (run == 8'(`TWE_FILT_CYC - 1)) begin
            run <= 8'h00;
            level_out <= sync_b;
        end else begin
            run <= run + 8'h01;
        end
    end
endmodule

// ==========================================
// Device end
module twe_slave
    import twe_pkg::*;
#(
    parameter int unsigned TW_CYC = `TWE_TW_CYC
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic write_protect_in,
    output logic prog_busy_out,
    twe_link_if.slave link
);
    // Filtered line levels and their previous values
    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;
    // Bus events
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    // Protocol state
    twe_sl_state_t state;
    logic [3:0] cnt;
    twe_byte_t rx;
    twe_byte_t tx;
    twe_addr_t addr;
    logic rd_cmd;
    logic wp_hit;
    logic sda_low;
    logic [31:0] prog_cnt;
    // Page latches, one per low address value
    twe_byte_t pbuf [`TWE_PAGE];
    logic [`TWE_PAGE-1:0] pvalid;
    logic wr_take;
    logic prog_done;
    twe_byte_t mem [`TWE_DEPTH];

    // ==========================================
    // Line conditioning
    twe_deglitch u_scl (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .line_in(link.scl),
        .level_out(scl_f)
    );
    twe_deglitch u_sda (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .line_in(link.sda),
        .level_out(sda_f)
    );

    // Previous filtered levels for edge detection
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    assign scl_rise = scl_f & ~scl_q;
    assign scl_fall = ~scl_f & scl_q;
    assign start_det = scl_f & scl_q & sda_q & ~sda_f;
    assign stop_det = scl_f & scl_q & ~sda_q & sda_f;

    // Data byte accepted into the page latches
    assign wr_take = (state == SL_WR) && scl_fall && (cnt == `TWE_ACK_BIT) && !wp_hit;
    assign prog_done = (state == SL_PROG) && (prog_cnt == TW_CYC - 1);

    // ==========================================
    // Protocol machine
    // reset holds the machine idle; no event is seen during it
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= SL_IDLE;
            cnt <= 4'h0;
            rx <= 8'h00;
            tx <= 8'h00;
            addr <= '0;
            rd_cmd <= 1'b0;
            wp_hit <= 1'b0;
            sda_low <= 1'b0;
        end else if (state == SL_PROG) begin
            sda_low <= 1'b0;
            if (prog_done) begin
                state <= SL_IDLE;
            end
        end else if (start_det) begin
            // only a start wakes the machine
            state <= SL_ADDR;
            cnt <= 4'h0;
            sda_low <= 1'b0;
            // low, as a floating pin reads, leaves writes open
            wp_hit <= write_protect_in;
        end else if (stop_det) begin
            sda_low <= 1'b0;
            if ((state == SL_WR) && (pvalid != '0) && !wp_hit) begin
                state <= SL_PROG;
            end else begin
                state <= SL_IDLE;
            end
        end else begin
            case (state)
                SL_IDLE: begin
                    // Standby: nothing but start matters
                    sda_low <= 1'b0;
                end
                SL_ADDR: begin
                    // protection seen during the address byte
                    wp_hit <= wp_hit | write_protect_in;
                    if (scl_rise) begin
                        rx <= {rx[6:0], sda_f};
                        cnt <= cnt + 4'h1;
                    end else if (scl_fall && (cnt == `TWE_ACK_BIT)) begin
                        // one byte carries address and direction
                        addr <= rx[7:1];
                        rd_cmd <= rx[`TWE_RW_BIT];
                        sda_low <= 1'b1;
                        state <= SL_AACK;
                    end
                end
                SL_AACK: begin
                    if (scl_fall) begin
                        cnt <= 4'h0;
                        if (rd_cmd) begin
                            // First read bit goes out on this fall
                            tx <= mem[addr];
                            sda_low <= ~mem[addr][7];
                            state <= SL_RD;
                        end else begin
                            sda_low <= 1'b0;
                            state <= SL_WR;
                        end
                    end
                end
                SL_WR: begin
                    if (scl_rise) begin
                        rx <= {rx[6:0], sda_f};
                        cnt <= cnt + 4'h1;
                    end else if (scl_fall && (cnt == `TWE_ACK_BIT)) begin
                        sda_low <= ~wp_hit;
                        state <= SL_DACK;
                    end
                end
                SL_DACK: begin
                    if (scl_fall) begin
                        sda_low <= 1'b0;
                        cnt <= 4'h0;
                        state <= SL_WR;
                        // only the low two bits advance
                        if (!wp_hit) begin
                            addr[1:0] <= addr[1:0] + 2'h1;
                        end
                    end
                end
                SL_RD: begin
                    if (scl_rise) begin
                        cnt <= cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == `TWE_ACK_BIT) begin
                            sda_low <= 1'b0;
                            state <= SL_RACK;
                        end else begin
                            tx <= {tx[6:0], 1'b0};
                            sda_low <= ~tx[6];
                        end
                    end
                end
                SL_RACK: begin
                    // master ack asks for the next byte
                    if (scl_rise) begin
                        if (sda_f) begin
                            state <= SL_IDLE;
                        end else begin
                            addr <= addr + 7'h01;
                        end
                    end else if (scl_fall) begin
                        cnt <= 4'h0;
                        tx <= mem[addr];
                        sda_low <= ~mem[addr][7];
                        state <= SL_RD;
                    end
                end
                default: begin
                    state <= SL_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Page latches
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pvalid <= '0;
        end else if (start_det && (state != SL_PROG)) begin
            pvalid <= '0;
        end else if (prog_done) begin
            pvalid <= '0;
        end else if (wr_take) begin
            // A rolled-over index overwrites its earlier byte
            pvalid[addr[1:0]] <= 1'b1;
        end
    end

    // Latch data; no reset needed, guarded by pvalid
    always_ff @(posedge clock_in) begin
        if (wr_take) begin
            pbuf[addr[1:0]] <= rx;
        end
    end

    // ==========================================
    // Self-timed programming
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prog_cnt <= 32'h0000_0000;
        end else if (state == SL_PROG) begin
            prog_cnt <= prog_cnt + 32'h0000_0001;
        end else begin
            prog_cnt <= 32'h0000_0000;
        end
    end

    // latched bytes enter the row at cycle end
    // Array is not reset: contents survive reset as in a nonvolatile part
    always_ff @(posedge clock_in) begin
        if (prog_done) begin
            for (int i = 0; i < `TWE_PAGE; i++) begin
                if (pvalid[i]) begin
                    mem[{addr[6:2], 2'(i)}] <= pbuf[i];
                end
            end
        end
    end

    assign link.s_sda_out = 1'b0;
    assign link.s_sda_oe = sda_low;
    assign prog_busy_out = (state == SL_PROG);
endmodule
`default_nettype wire

// ---- hdl/twe_regs.svh ----
// Timing counts and field constants for the two-wire EEPROM link.
// Assumes a 250 MHz system clock on both ends.
`ifndef TWE_REGS_SVH
`define TWE_REGS_SVH
// ==========================================
// Clock and timing
`define TWE_CLK_NS 4
`define TWE_LP_NS 100
`define TWE_FILT_CYC (`TWE_LP_NS / `TWE_CLK_NS)
`define TWE_TW_MS 10
`define TWE_TW_CYC ((`TWE_TW_MS * 1000000) / `TWE_CLK_NS)
`define TWE_FSCL_KHZ 100
`define TWE_QTR_NS (1000000 / (`TWE_FSCL_KHZ * 4))
`define TWE_QTR_CYC (`TWE_QTR_NS / `TWE_CLK_NS)
// ==========================================
// Array and frame layout
`define TWE_DEPTH 128
`define TWE_ADDR_W 7
`define TWE_PAGE 4
`define TWE_RW_BIT 0
`define TWE_ACK_BIT 4'h8
`endif

// ---- hdl/twe_pkg.sv ----
// Types shared by both ends of the two-wire EEPROM link.
// Assumes twe_regs.svh is on the include path.
`default_nettype none
`include "twe_regs.svh"
package twe_pkg;
    // ==========================================
    // Device state
    typedef enum logic [2:0] {
        SL_IDLE = 3'b000,
        SL_ADDR = 3'b001,
        SL_AACK = 3'b010,
        SL_WR = 3'b011,
        SL_DACK = 3'b100,
        SL_RD = 3'b101,
        SL_RACK = 3'b110,
        SL_PROG = 3'b111
    } twe_sl_state_t;
    // ==========================================
    // Master state
    typedef enum logic [1:0] {
        MS_IDLE = 2'b00,
        MS_START = 2'b01,
        MS_BIT = 2'b10,
        MS_STOP = 2'b11
    } twe_ms_state_t;
    typedef logic [`TWE_ADDR_W-1:0] twe_addr_t;
    typedef logic [7:0] twe_byte_t;
endpackage
`default_nettype wire

// ---- hdl/twe_link_if.sv ----
// Two-wire link between bus master and EEPROM device.
// Assumes open-drain drivers; the wire levels are resolved here.
`default_nettype none
interface twe_link_if;
    // Master clock pin
    logic m_scl_out;
    logic m_scl_oe;
    // Master data pin
    logic m_sda_out;
    logic m_sda_oe;
    // Device data pin
    logic s_sda_out;
    logic s_sda_oe;
    // Resolved line levels, pulled up when nobody pulls low
    logic scl;
    logic sda;
    assign scl = ~(m_scl_oe & ~m_scl_out);
    assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));
    modport master (output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe, input scl, sda);
    modport slave (output s_sda_out, s_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// ---- hdl/twe_master.sv ----
// Bus master end of the two-wire EEPROM link, with a read buffer.
// Assumes the link lines are synchronous to clock_in.
`default_nettype none
`include "twe_regs.svh"
module twe_master
    import twe_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic cmd_read_in,
    input wire logic [6:0] cmd_addr_in,
    input wire logic [1:0] cmd_len_in,
    input wire logic wdata_valid_in,
    output logic wdata_ready_out,
    input wire logic [7:0] wdata_in,
    output logic rdata_valid_out,
    input wire logic rdata_ready_in,
    output logic [7:0] rdata_out,
    output logic nack_out,
    output logic busy_out,
    twe_link_if.master link
);
    // Quarter-bit tick divider
    logic [15:0] div;
    logic q_tick;
    // Sequencer
    twe_ms_state_t state;
    logic [1:0] phase;
    logic [3:0] bit_idx;
    logic [2:0] byte_cnt;
    logic [2:0] last_byte;
    logic rd;
    twe_byte_t sh;
    logic scl_low;
    logic sda_low;
    logic tx_mode;
    logic stall;
    logic push;
    // Two-entry read buffer
    twe_byte_t buf_mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;

    // ==========================================
    // Divider: one tick per quarter SCL period
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div <= 16'h0000;
        end else if (div == 16'(`TWE_QTR_CYC - 1)) begin
            div <= 16'h0000;
        end else begin
            div <= div + 16'h0001;
        end
    end
    assign q_tick = (div == 16'(`TWE_QTR_CYC - 1));

    // Master drives data bits except on read data and its ack slots
    assign tx_mode = !rd || (byte_cnt == 3'h0);
    // Hold SCL low when write data is missing or the buffer is full
    assign stall = (state == MS_BIT) && (phase == 2'h0) && (
        ((bit_idx == 4'h0) && (byte_cnt != 3'h0) && !rd && !wdata_valid_in) ||
        ((bit_idx == `TWE_ACK_BIT) && rd && (byte_cnt != 3'h0) && (count == 2'h2)));
    assign push = q_tick && (state == MS_BIT) && (phase == 2'h0) && !stall &&
        (bit_idx == `TWE_ACK_BIT) && rd && (byte_cnt != 3'h0);
    assign wdata_ready_out = q_tick && (state == MS_BIT) && (phase == 2'h0) &&
        (bit_idx == 4'h0) && (byte_cnt != 3'h0) && !rd && wdata_valid_in;
    assign cmd_ready_out = (state == MS_IDLE);

    // ==========================================
    // Frame sequencer
    // master alone clocks and starts frames
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= MS_IDLE;
            phase <= 2'h0;
            bit_idx <= 4'h0;
            byte_cnt <= 3'h0;
            last_byte <= 3'h0;
            rd <= 1'b0;
            sh <= 8'h00;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            nack_out <= 1'b0;
        end else if (state == MS_IDLE) begin
            if (cmd_valid_in) begin
                // address MSB first, read is one
                sh <= {cmd_addr_in, cmd_read_in};
                rd <= cmd_read_in;
                last_byte <= {1'b0, cmd_len_in} + 3'h1;
                byte_cnt <= 3'h0;
                nack_out <= 1'b0;
                phase <= 2'h0;
                state <= MS_START;
            end
        end else if (q_tick && !stall) begin
            phase <= phase + 2'h1;
            case (state)
                MS_START: begin
                    // start while SCL high, then clock low
                    if (phase == 2'h0) begin
                        sda_low <= 1'b1;
                    end else if (phase == 2'h1) begin
                        scl_low <= 1'b1;
                        bit_idx <= 4'h0;
                        phase <= 2'h0;
                        state <= MS_BIT;
                    end
                end
                MS_BIT: begin
                    if (phase == 2'h0) begin
                        // data changes only with SCL low
                        if (bit_idx == `TWE_ACK_BIT) begin
                            // release, or ack all but the last read byte
                            sda_low <= rd && (byte_cnt != 3'h0) && (byte_cnt != last_byte);
                        end else if ((bit_idx == 4'h0) && (byte_cnt != 3'h0) && !rd) begin
                            sh <= wdata_in;
                            sda_low <= ~wdata_in[7];
                        end else begin
                            sda_low <= tx_mode & ~sh[7];
                        end
                    end else if (phase == 2'h2) begin
                        scl_low <= 1'b0;
                    end else if (phase == 2'h3) begin
                        scl_low <= 1'b1;
                        if (bit_idx != `TWE_ACK_BIT) begin
                            sh <= {sh[6:0], link.sda};
                            bit_idx <= bit_idx + 4'h1;
                        end else begin
                            bit_idx <= 4'h0;
                            byte_cnt <= byte_cnt + 3'h1;
                            if (tx_mode && link.sda) begin
                                nack_out <= 1'b1;
                                state <= MS_STOP;
                            end else if (byte_cnt == last_byte) begin
                                state <= MS_STOP;
                            end
                        end
                    end
                end
                MS_STOP: begin
                    // stop is SDA rise with SCL high
                    if (phase == 2'h0) begin
                        sda_low <= 1'b1;
                    end else if (phase == 2'h1) begin
                        scl_low <= 1'b0;
                    end else if (phase == 2'h2) begin
                        sda_low <= 1'b0;
                    end else begin
                        state <= MS_IDLE;
                    end
                end
                default: begin
                    state <= MS_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Read buffer: full count stalls SCL, so no byte is lost
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (rdata_valid_out && rdata_ready_in) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + 2'(push) - 2'(rdata_valid_out && rdata_ready_in);
        end
    end

    // Buffer storage
    always_ff @(posedge clock_in) begin
        if (push) begin
            buf_mem[wr_ptr] <= sh;
        end
    end

    assign rdata_valid_out = (count != 2'h0);
    assign rdata_out = buf_mem[rd_ptr];
    assign busy_out = (state != MS_IDLE);
    // Open-drain pins
    assign link.m_scl_out = 1'b0;
    assign link.m_scl_oe = scl_low;
    assign link.m_sda_out = 1'b0;
    assign link.m_sda_oe = sda_low;
endmodule
`default_nettype wire

// ---- bench/twe_monitor.sv ----
// Checker on the wires between the master and device ends of the link.
// Assumes a single clock domain, with the lines synchronous to clock_in.
`default_nettype none
module twe_monitor (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic m_scl_oe,
    input wire logic m_sda_oe,
    input wire logic s_sda_out,
    input wire logic s_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Frame tracking
    logic scl_q, sda_q, in_frame, rd, nbyte; // nbyte: address byte done
    logic [3:0] bits; // SCL rises seen in the current byte
    wire start_seen = scl & scl_q & sda_q & ~sda;
    wire stop_seen = scl & scl_q & ~sda_q & sda;
    // Bit counter restarts on every START or STOP, so a repeated START resyncs it
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {scl_q, sda_q} <= 2'h3;
            {in_frame, bits, nbyte, rd} <= 7'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_seen || stop_seen) begin
                in_frame <= start_seen;
                {bits, nbyte, rd} <= 6'h00;
            end else if (scl && !scl_q) begin
                bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
                nbyte <= nbyte | (bits == 4'h8);
                rd <= (bits == 4'h7 && !nbyte) ? sda : rd;
            end
        end
    end
    // ==========================================
    // Assertions
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    od_drive_a: assert property (s_sda_oe |-> !s_sda_out) else $error("device drives sda high");
    reset_quiet_a: assert property ($rose(resetn_in) |-> !s_sda_oe && !m_sda_oe && !m_scl_oe)
        else $error("line driven at reset release");
    data_scl_low_a: assert property ($changed(s_sda_oe) |-> !scl) else $error("device sda moves with scl high");
    idle_silent_a: assert property (!in_frame |-> !s_sda_oe) else $error("device drives outside frame");
    addr_ack_a: assert property ($fell(scl) && bits == 4'h8 && !nbyte |-> ##[1:40] s_sda_oe)
        else $error("address ack late");
    ack_hold_a: assert property ($rose(scl) && bits == 4'h8 && !nbyte |-> s_sda_oe)
        else $error("address ack missing at ninth rise");
    wr_release_a: assert property ($rose(scl) && bits != 4'h8 && !rd |-> !s_sda_oe)
        else $error("device drives received data bit");
    rd_ack_free_a: assert property ($rose(scl) && bits == 4'h8 && rd && nbyte |-> !s_sda_oe)
        else $error("device holds sda in master ack");
    stop_ends_a: assert property (stop_seen |=> !s_sda_oe [*8]) else $error("device drives after stop");
    cover property (start_seen);
    cover property ($rose(scl) && bits == 4'h8 && !nbyte && s_sda_oe);
    cover property ($rose(scl) && bits == 4'h8 && rd && nbyte);
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking bench: master and device ends joined by the link interface.
// Assumes the hdl/ files are compiled first; one frame takes about 48k cycles.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TW = 200; // Short programming time keeps the run brief
    logic clock_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cmd_valid, cmd_read, wdata_valid, rdata_ready, wp;
    logic [6:0] addr;
    logic [7:0] wdata, wbyte;
    logic cmd_ready, wdata_ready, rdata_valid, nack, busy, prog_busy;
    logic [7:0] rdata;
    int num_errors = 0;
    int checked = 0;
    int n;
    // Programming cycles and write-data handshakes, counted at mid-cycle where both are settled
    int prog_cycles = 0;
    int wtakes = 0;
    always #2 clock_in = ~clock_in;
    always @(negedge clock_in) begin
        prog_cycles += (prog_busy === 1'b1);
        wtakes += (wdata_ready === 1'b1);
    end
    // ==========================================
    // Both ends and the checker
    twe_link_if twe_link_if_i ();
    twe_master twe_master_i (.clock_in(clock_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid),
        .cmd_ready_out(cmd_ready), .cmd_read_in(cmd_read), .cmd_addr_in(addr), .cmd_len_in(2'h0),
        .wdata_valid_in(wdata_valid), .wdata_ready_out(wdata_ready), .wdata_in(wdata),
        .rdata_valid_out(rdata_valid), .rdata_ready_in(rdata_ready), .rdata_out(rdata),
        .nack_out(nack), .busy_out(busy), .link(twe_link_if_i));
    twe_slave #(.TW_CYC(TW)) twe_slave_i (.clock_in(clock_in), .resetn_in(resetn_in),
        .write_protect_in(wp), .prog_busy_out(prog_busy), .link(twe_link_if_i));
    twe_monitor twe_monitor_i (.clock_in(clock_in), .resetn_in(resetn_in), .m_scl_oe(twe_link_if_i.m_scl_oe),
        .m_sda_oe(twe_link_if_i.m_sda_oe), .s_sda_out(twe_link_if_i.s_sda_out),
        .s_sda_oe(twe_link_if_i.s_sda_oe), .scl(twe_link_if_i.scl), .sda(twe_link_if_i.sda));
    // ==========================================
    // Helpers
    // Protected writes leave the old contents in place
    function automatic logic [7:0] exp_read(input logic prot, input logic [7:0] old, input logic [7:0] neww);
        return prot ? old : neww;
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %0h got %0h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One command; cmd_ready is high when idle, so the next edge takes it
    task automatic run_cmd(input logic rd);
        @(posedge clock_in) #1;
        check("cmd_ready", 32'h1, cmd_ready);
        cmd_read = rd;
        cmd_valid = 1'b1;
        @(posedge clock_in) #1;
        cmd_valid = 1'b0;
        for (n = 0; busy !== 1'b0 && n < 60000; n++) @(posedge clock_in) #1;
        check("busy", 32'h0, busy);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {cmd_valid, cmd_read, wdata_valid, rdata_ready, wp} = 5'h00; // wp low: floating pin reads low
        addr = 7'h00;
        wdata = 8'h00;
        repeat (10) @(posedge clock_in);
        #1 resetn_in = 1'b1;
        void'($urandom(68));
        addr = 7'($urandom);
        wbyte = 8'($urandom);
        // Byte write with data already waiting
        wdata = wbyte;
        wdata_valid = 1'b1;
        run_cmd(1'b0);
        wdata_valid = 1'b0;
        check("write_nack", 32'h0, nack);
        check("wdata_takes", 32'h1, wtakes);
        // The short cycle may already be over when the frame ends, so it is counted alongside
        for (n = 0; prog_busy === 1'b1 && n < 1000; n++) @(posedge clock_in) #1;
        check("prog_len", TW, prog_cycles);
        $display("test byte_write done");
        // Read back with the byte left undrained in the buffer until the frame ends; one byte never fills it, so SCL is not stalled
        run_cmd(1'b1);
        check("read_nack", 32'h0, nack);
        check("rdata_valid", 32'h1, rdata_valid);
        check("rdata", exp_read(wp, 8'h00, wbyte), rdata);
        rdata_ready = 1'b1;
        @(posedge clock_in) #1;
        rdata_ready = 1'b0;
        check("rdata_empty", 32'h0, rdata_valid);
        $display("test read_back done");
        summarize();
    end
    // Watchdog sized well past two frames plus programming
    initial begin
        #(4 * 130000);
        num_errors++;
        $display("ERROR watchdog expected done got timeout");
        summarize();
    end
endmodule
`default_nettype wire
